//--- logic/sbu_regs.svh
// register offsets, field positions and timing for the serial bus unit
`ifndef SBU_REGS_SVH
`define SBU_REGS_SVH

// register byte offsets
`define SBU_OFS_CTRL_ONE 8'h00
`define SBU_OFS_CTRL_TWO 8'h04
`define SBU_OFS_STATUS 8'h08
`define SBU_OFS_DATA_BUF 8'h0c
`define SBU_OFS_OWN_ADDR 8'h10

// control_one fields
`define SBU_C1_BC_LSB 0
`define SBU_C1_BC_MSB 2
`define SBU_C1_ACK 4

// control_two fields (status_reg shares the upper positions)
`define SBU_C2_MST 7
`define SBU_C2_TRX 6
`define SBU_C2_BB 5
`define SBU_C2_PIN 4

// reset values and the general call address
`define SBU_RST_BC 3'h0
`define SBU_RST_OWN_ADDR 7'h00
`define SBU_GEN_CALL 8'h00

// timing: scl half period in ns and core clock period in ns
`define SBU_SCL_HALF_NS 5000
`define SBU_CLK_NS 20

`endif

//--- logic/sbu_pkg.sv
// types shared by the serial bus unit
package sbu_pkg;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_START = 9'h002,
        ST_LOW = 9'h004,
        ST_HIGH = 9'h008,
        ST_WAIT = 9'h010,
        ST_STOP_LOW = 9'h020,
        ST_STOP_HIGH = 9'h040,
        ST_SLV_ADDR = 9'h080,
        ST_SLV_ACK = 9'h100
    } sbu_state_e;

    // status_reg layout, msb first
    typedef struct packed {
        logic master_select;
        logic trx;
        logic bus_busy_flag;
        logic pending_release;
        logic rsv;
        logic addressed;
        logic general_call;
        logic last_rx_bit;
    } sbu_status_s;

endpackage

//--- logic/sbu_core.sv
// serial bus unit: two-wire master start, address and word transfer; slave start detect, address and ack only
`timescale 1ns/10ps
`include "sbu_regs.svh"

module sbu_core
    import sbu_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_O,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    output logic SERIAL_BUS_IRQ_O
);

    localparam int HALF_CYC = (`SBU_SCL_HALF_NS + `SBU_CLK_NS - 1) /
        `SBU_CLK_NS;
    localparam logic [8:0] HALF = 9'(HALF_CYC);
    localparam logic [8:0] QUARTER = 9'(HALF_CYC / 2);

    // word length in clocks, zero code meaning a full byte
    function automatic logic [3:0] word_bits(input logic [2:0] bc);
        word_bits = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
    endfunction

    // =========================================================
    // pin synchronisers and bus condition detect
    // =========================================================
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;

    // two flops before use; third stage only for edge compare
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
        end else begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {SCL_I, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {SDA_I, sda_s1_q, sda_s2_q};
        end
    end

    wire scl_hi = scl_s2_q;
    wire sda_in = sda_s2_q;
    wire scl_rise = scl_s2_q & ~scl_s3_q;
    wire scl_fall = ~scl_s2_q & scl_s3_q;
    wire start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    wire stop_det = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

    // =========================================================
    // wishbone decode
    // =========================================================
    logic ack_q;
    wire acc = WB_CYC_I & WB_STB_I & ~ack_q;
    wire wr = acc & WB_WE_I & WB_SEL_I[0];
    wire rd = acc & ~WB_WE_I;
    wire [7:0] wdat = WB_DAT_I[7:0];
    wire [7:0] ofs = {WB_ADR_I[7:2], 2'b00};
    wire sel_c1 = (ofs == `SBU_OFS_CTRL_ONE);
    wire sel_c2 = (ofs == `SBU_OFS_CTRL_TWO);
    wire sel_st = (ofs == `SBU_OFS_STATUS);
    wire sel_db = (ofs == `SBU_OFS_DATA_BUF);
    wire sel_oa = (ofs == `SBU_OFS_OWN_ADDR);
    wire db_wr = wr & sel_db;
    wire db_acc = (wr | rd) & sel_db;
    wire c2_wr = wr & sel_c2;

    // =========================================================
    // state
    // =========================================================
    sbu_state_e state_q, state_d;
    logic [8:0] cnt_q, cnt_d;
    logic [3:0] bits_q, bits_d;
    logic [7:0] shift_q, shift_d;
    logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, sda_nxt_q, sda_nxt_d;
    logic mst_q, mst_d, trx_q, trx_d, bb_q, bb_d, pin_q, pin_d;
    logic aas_q, aas_d, ado_q, ado_d, lrb_q, lrb_d;
    logic word_ack_q, word_ack_d, is_addr_q, is_addr_d, dir_q, dir_d;
    logic irq_d, irq_q;
    logic [2:0] bc_q;
    logic ack_mode_q;
    logic [6:0] own_addr_q;

    wire tdone = (cnt_q == 9'h000);
    wire [8:0] cnt_dec = tdone ? 9'h000 : cnt_q - 9'h001;
    wire [7:0] shift_in = {shift_q[6:0], sda_in};
    wire in_ack = word_ack_q & (bits_q == 4'h1);
    wire next_ack = word_ack_q & (bits_q == 4'h2);
    wire tx_role = is_addr_q | trx_q;
    wire [3:0] new_bits = word_bits(bc_q) + {3'h0, ack_mode_q};
    wire addr_match = (shift_in[7:1] == own_addr_q) |
        (shift_in == `SBU_GEN_CALL);
    wire start_req = c2_wr & wdat[`SBU_C2_MST] & wdat[`SBU_C2_TRX] &
        wdat[`SBU_C2_BB] & wdat[`SBU_C2_PIN] & ~bb_q;
    wire stop_req = c2_wr & wdat[`SBU_C2_MST] & wdat[`SBU_C2_TRX] &
        ~wdat[`SBU_C2_BB] & wdat[`SBU_C2_PIN] & bb_q;

    sbu_status_s status;
    assign status = '{master_select: mst_q, trx: trx_q, bus_busy_flag: bb_q,
        pending_release: pin_q, rsv: 1'b0, addressed: aas_q,
        general_call: ado_q, last_rx_bit: lrb_q};

    // =========================================================
    // next-state logic
    // =========================================================
    // one process so flag set/clear priorities sit side by side
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_dec;
        bits_d = bits_q;
        shift_d = db_wr ? wdat : shift_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        sda_nxt_d = sda_nxt_q;
        mst_d = c2_wr ? wdat[`SBU_C2_MST] : mst_q;
        trx_d = c2_wr ? wdat[`SBU_C2_TRX] : trx_q;
        bb_d = bb_q;
        pin_d = pin_q;
        aas_d = db_acc ? 1'b0 : aas_q;
        ado_d = ado_q;
        lrb_d = lrb_q;
        word_ack_d = word_ack_q;
        is_addr_d = is_addr_q;
        dir_d = dir_q;
        irq_d = 1'b0;
        // bus busy follows conditions seen on the wires
        if (start_det | stop_det) begin
            bb_d = start_det;
            ado_d = 1'b0;
        end
        // release set by access or writing one
        if (db_acc | (c2_wr & wdat[`SBU_C2_PIN])) begin
            pin_d = 1'b1;
        end
        unique case (state_q)
            ST_IDLE: begin
                scl_oe_d = 1'b0;
                sda_oe_d = 1'b0;
                if (start_req) begin
                    state_d = ST_START;
                    cnt_d = HALF;
                    sda_oe_d = 1'b1;
                end else if (start_det & ~mst_q) begin
                    state_d = ST_SLV_ADDR;
                    bits_d = 4'h8;
                end
            end
            ST_START: begin
                // nine clocks for address plus ack
                if (tdone) begin
                    state_d = ST_LOW;
                    cnt_d = HALF;
                    scl_oe_d = 1'b1;
                    bits_d = 4'h9;
                    word_ack_d = 1'b1;
                    is_addr_d = 1'b1;
                    dir_d = shift_q[0];
                    sda_nxt_d = ~shift_q[7];
                end
            end
            ST_LOW: begin
                // data moves mid-low so it never changes near an edge
                if (cnt_q == QUARTER) begin
                    sda_oe_d = sda_nxt_q;
                end
                if (tdone) begin
                    state_d = ST_HIGH;
                    cnt_d = HALF;
                    scl_oe_d = 1'b0;
                end
            end
            ST_HIGH: begin
                if (!scl_hi) begin
                    // another device stretching; restart the high time
                    cnt_d = HALF;
                end else if (tdone) begin
                    state_d = ST_LOW;
                    cnt_d = HALF;
                    scl_oe_d = 1'b1;
                    bits_d = bits_q - 4'h1;
                    // ack or last bit into the flag
                    lrb_d = sda_in;
                    if (!in_ack) begin
                        shift_d = shift_in;
                    end
                    if (bits_q == 4'h1) begin
                        // irq and clear release on last falling edge
                        // sda is let go in the wait state, not on this edge
                        state_d = ST_WAIT;
                        irq_d = 1'b1;
                        if (is_addr_q & ~sda_in) begin
                            trx_d = ~dir_q;
                        end
                    end else if (next_ack) begin
                        // receiver acks; no ack leaves high
                        sda_nxt_d = ~tx_role & ack_mode_q;
                    end else begin
                        sda_nxt_d = tx_role & ~shift_in[7];
                    end
                end
            end
            ST_WAIT: begin
                scl_oe_d = 1'b1;
                sda_oe_d = 1'b0;
                // slave lets scl go a full low time after release
                if (!pin_q) begin
                    cnt_d = HALF;
                end
                if (stop_req) begin
                    state_d = ST_STOP_LOW;
                    cnt_d = HALF;
                    scl_oe_d = 1'b1;
                    sda_oe_d = 1'b1;
                end else if (pin_q & mst_q) begin
                    state_d = ST_LOW;
                    cnt_d = HALF;
                    scl_oe_d = 1'b1;
                    bits_d = new_bits;
                    word_ack_d = ack_mode_q;
                    is_addr_d = 1'b0;
                    sda_nxt_d = trx_q & ~shift_q[7];
                end else if (pin_q & tdone) begin
                    state_d = ST_IDLE;
                end
            end
            ST_STOP_LOW: begin
                if (tdone) begin
                    state_d = ST_STOP_HIGH;
                    cnt_d = HALF;
                    scl_oe_d = 1'b0;
                end
            end
            ST_STOP_HIGH: begin
                // wait for scl to be let go by others
                if (!scl_hi) begin
                    cnt_d = HALF;
                end else if (tdone) begin
                    state_d = ST_IDLE;
                    sda_oe_d = 1'b0;
                    mst_d = 1'b0;
                    trx_d = 1'b0;
                end
            end
            ST_SLV_ADDR: begin
                if (stop_det) begin
                    state_d = ST_IDLE;
                end else if (scl_rise) begin
                    shift_d = shift_in;
                    lrb_d = sda_in; // last bit seen on a rising clock
                    bits_d = bits_q - 4'h1;
                    if (bits_q == 4'h1) begin
                        state_d = ST_SLV_ACK;
                        is_addr_d = addr_match;
                        dir_d = sda_in;
                    end
                end
            end
            ST_SLV_ACK: begin
                // ack the ninth clock on a match
                if (scl_fall & (bits_q == 4'h0)) begin
                    sda_oe_d = is_addr_q;
                    bits_d = 4'h1;
                    if (!is_addr_q) begin
                        state_d = ST_IDLE;
                    end
                end else if (scl_fall) begin
                    state_d = ST_WAIT;
                    sda_oe_d = 1'b0;
                    scl_oe_d = 1'b1;
                    irq_d = 1'b1;
                    aas_d = 1'b1;
                    ado_d = (shift_q == `SBU_GEN_CALL);
                    trx_d = dir_q;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // word end clears release; hardware wins
        if (irq_d) begin
            pin_d = 1'b0;
        end
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            cnt_q <= 9'h000;
            bits_q <= 4'h0;
            shift_q <= 8'h00;
            {scl_oe_q, sda_oe_q, sda_nxt_q} <= 3'h0;
            {mst_q, trx_q, bb_q, pin_q} <= 4'h1;
            {aas_q, ado_q, lrb_q, irq_q} <= 4'h0;
            {word_ack_q, is_addr_q, dir_q} <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bits_q <= bits_d;
            shift_q <= shift_d;
            {scl_oe_q, sda_oe_q, sda_nxt_q} <= {scl_oe_d, sda_oe_d, sda_nxt_d};
            {mst_q, trx_q, bb_q, pin_q} <= {mst_d, trx_d, bb_d, pin_d};
            {aas_q, ado_q, lrb_q, irq_q} <= {aas_d, ado_d, lrb_d, irq_d};
            {word_ack_q, is_addr_q, dir_q} <= {word_ack_d, is_addr_d, dir_d};
        end
    end

    // software configuration registers
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bc_q <= `SBU_RST_BC;
            ack_mode_q <= 1'b0;
            own_addr_q <= `SBU_RST_OWN_ADDR;
        end else begin
            if (wr & sel_c1) begin
                bc_q <= wdat[`SBU_C1_BC_MSB:`SBU_C1_BC_LSB];
                ack_mode_q <= wdat[`SBU_C1_ACK];
            end
            if (wr & sel_oa) begin
                own_addr_q <= wdat[6:0];
            end
        end
    end

    // read mux; unmapped offsets answer with zero
    // buffer read shows raw shift contents
    wire [7:0] rd_byte = sel_c1 ? {3'h0, ack_mode_q, 1'b0, bc_q} :
        (sel_c2 | sel_st) ? status :
        sel_db ? shift_q :
        sel_oa ? {1'b0, own_addr_q} : 8'h00;

    // single-wait-state ack, data registered with it
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_q <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            WB_DAT_O <= {24'h00_0000, rd_byte};
        end
    end

    assign WB_ACK_O = ack_q;
    // open drain: only ever pull low
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE_O = scl_oe_q;
    assign SDA_OE_O = sda_oe_q;
    assign SERIAL_BUS_IRQ_O = irq_q;

endmodule

//--- tb/sbu_core_assertions.sv
// concurrent checks on the serial bus unit ports
`timescale 1ns/10ps
module sbu_core_assertions (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic SCL_I,
    input wire logic SCL_O,
    input wire logic SCL_OE_O,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic SERIAL_BUS_IRQ_O
);
    // shortest legal low phase of the clock line, in core cycles
    localparam int LOW_MIN = 240;
    int low_q;
    // ==========================================================
    // helper: cycles the clock line has been pulled low
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            low_q <= 0;
        end else begin
            low_q <= SCL_OE_O ? low_q + 1 : 0;
        end
    end
    default clocking dc @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ==========================================================
    // register bus handshake
    ack_prompt_a: assert property
        (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");
    ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    rdata_upper_a: assert property
        (WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    // ==========================================================
    // wire side
    open_drain_a: assert property (!SCL_O && !SDA_O)
        else $error("pin driven high");
    irq_pulse_a: assert property (
        SERIAL_BUS_IRQ_O |=> !SERIAL_BUS_IRQ_O)
        else $error("irq longer than one cycle");
    irq_clock_low_a: assert property (
        SERIAL_BUS_IRQ_O |-> SCL_OE_O)
        else $error("irq without clock pulled low");
    irq_hold_a: assert property (
        SERIAL_BUS_IRQ_O |=> SCL_OE_O [*8])
        else $error("clock not held low after irq");
    low_time_a: assert property (
        $fell(SCL_OE_O) |-> low_q >= LOW_MIN)
        else $error("clock low phase too short");
    high_time_a: assert property (
        $fell(SCL_OE_O) |-> !SCL_OE_O [*8])
        else $error("clock high phase too short");
    cover property (SERIAL_BUS_IRQ_O && SCL_OE_O);
    cover property ($rose(SDA_OE_O) && SCL_I);
    cover property (WB_ACK_O && WB_WE_I);
endmodule

bind sbu_core sbu_core_assertions u_chk (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
    .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O),
    .SDA_OE_O(SDA_OE_O), .SERIAL_BUS_IRQ_O(SERIAL_BUS_IRQ_O));

//--- tb/sbu_target.sv
// behavioural two-wire target: acks one address, takes or sends bytes
`timescale 1ns/10ps
module sbu_target #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output logic [7:0] rx_o
);
    logic [7:0] sh;
    logic [7:0] tx;
    int n;
    int ph; // 0 idle, 1 address, 2 take bytes, 3 send bytes
    initial begin
        sda_oe_o = 1'b0;
        rx_o = 8'h00;
        sh = 8'h00;
        tx = 8'hc3;
        n = 0;
        ph = 0;
    end
    // ==========================================================
    // start and stop: data moves while the clock is high
    always @(sda_i) begin
        if (scl_i === 1'b1) begin
            ph = sda_i ? 0 : 1;
            n = 0;
            sda_oe_o = 1'b0;
        end
    end
    // sample on the rising clock; a nack ends sending
    always @(posedge scl_i) begin
        if (n < 8) begin
            sh = {sh[6:0], sda_i};
        end else if (ph == 3 && sda_i) begin
            ph = 0;
        end
        n = n + 1;
    end
    // drive only after the falling clock, so data never moves high
    always @(negedge scl_i) begin
        sda_oe_o = 1'b0;
        if (n == 8 && ph == 1) begin
            sda_oe_o = (sh[7:1] == ADDR);
            ph = (sh[7:1] != ADDR) ? 0 : (sh[0] ? 3 : 2);
        end else if (n == 8 && ph == 2) begin
            sda_oe_o = 1'b1;
            rx_o = sh;
        end else if (n == 8 && ph == 3) begin
            tx = tx + 8'h11;
        end
        if (n == 9) begin
            n = 0;
        end
        if (ph == 3 && n < 8) begin
            sda_oe_o = !tx[7 - n];
        end
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial bus unit
`timescale 1ns/10ps
`include "sbu_regs.svh"
module testbench;
    logic clk, rst_n, cyc, stb, we, seen;
    logic [7:0] adr, q, rx;
    logic [31:0] wdat, rdat;
    logic ack, scl_oe, sda_oe, irq, scl_o, sda_o, t_sda_oe;
    logic m_scl_oe, m_sda_oe;
    // wired-and lines with pull-ups
    wire scl = !(scl_oe | m_scl_oe);
    wire sda = !(sda_oe | t_sda_oe | m_sda_oe);
    int miscompares = 0;
    int cmp_count = 0;
    int irqs = 0;
    int edges = 0;
    sbu_core uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCL_I(scl),
        .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .SERIAL_BUS_IRQ_O(irq));
    sbu_target tgt (.scl_i(scl), .sda_i(sda), .sda_oe_o(t_sda_oe),
        .rx_o(rx));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
    always @(posedge scl) edges = edges + 1;
    // ==========================================================
    // helpers
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_up();
        miscompares++;
        close_out();
    endtask
    // one classic wishbone cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) give_up();
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic st(input logic [7:0] e);
        wb(1'b0, `SBU_OFS_STATUS, 8'h00);
        chk(q, e);
    endtask
    // access, wait for the irq, compare clock count
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [7:0] d, input int n);
        int k, i0;
        i0 = irqs;
        edges = 0;
        wb(w, a, d);
        k = 0;
        while (irqs == i0 && k < 20000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 20000) give_up();
        chk(edges, n);
    endtask
    task automatic wait_free();
        int k;
        k = 0;
        do begin
            wb(1'b0, `SBU_OFS_STATUS, 8'h00);
            k++;
        end while (q[5] !== 1'b0 && k < 400);
        if (q[5] !== 1'b0) give_up();
        chk(q[7:5], 3'h0);
    endtask
    // one bench-made clock, 160 ns, data set a cycle after the fall
    task automatic m_clk(input logic v);
        @(posedge clk);
        m_sda_oe <= !v;
        repeat (3) @(posedge clk);
        m_scl_oe <= 1'b0;
        repeat (4) @(posedge clk);
        seen = sda;
        m_scl_oe <= 1'b1;
    endtask
    // bench as bus master addressing the unit
    task automatic slave_case(input logic [7:0] b, input logic [7:0] e);
        int k, i0;
        i0 = irqs;
        m_sda_oe <= 1'b1;
        repeat (4) @(posedge clk);
        m_scl_oe <= 1'b1;
        for (k = 7; k >= 0; k--) m_clk(b[k]);
        m_clk(1'b1);
        chk(seen, 1'b0);
        k = 0;
        while (irqs == i0 && k < 100) begin
            @(posedge clk);
            k++;
        end
        if (k >= 100) give_up();
        st(e);
        wb(1'b1, `SBU_OFS_CTRL_TWO, 8'h10);
        m_sda_oe <= 1'b1;
        repeat (300) @(posedge clk);
        m_scl_oe <= 1'b0;
        repeat (4) @(posedge clk);
        m_sda_oe <= 1'b0;
        wait_free();
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h00000000;
        m_scl_oe = 1'b0;
        m_sda_oe = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        st(8'h10);
        wb(1'b0, 8'h20, 8'h00);
        chk(q, 8'h00);
        wb(1'b1, `SBU_OFS_CTRL_ONE, 8'h10);
        wb(1'b1, `SBU_OFS_DATA_BUF, 8'h54);
        xfer(1'b1, `SBU_OFS_CTRL_TWO, 8'hf0, 9);
        st(8'he0);
        edges = 0;
        wb(1'b1, `SBU_OFS_CTRL_TWO, 8'he0);
        repeat (600) @(posedge clk);
        chk(edges, 0);
        st(8'he0);
        xfer(1'b1, `SBU_OFS_DATA_BUF, 8'h5a, 9);
        chk(rx, 8'h5a);
        wb(1'b1, `SBU_OFS_CTRL_ONE, 8'h13);
        xfer(1'b1, `SBU_OFS_DATA_BUF, 8'hb0, 4);
        st(8'he1);
        wb(1'b1, `SBU_OFS_CTRL_TWO, 8'hd0);
        wait_free();
        $display("test master write done");
        wb(1'b1, `SBU_OFS_CTRL_ONE, 8'h10);
        wb(1'b1, `SBU_OFS_DATA_BUF, 8'h55);
        xfer(1'b1, `SBU_OFS_CTRL_TWO, 8'hf0, 9);
        st(8'ha0);
        xfer(1'b0, `SBU_OFS_DATA_BUF, 8'h00, 9);
        st(8'ha0);
        xfer(1'b0, `SBU_OFS_DATA_BUF, 8'h00, 9);
        chk(q, 8'hc3);
        wb(1'b1, `SBU_OFS_CTRL_ONE, 8'h00);
        xfer(1'b0, `SBU_OFS_DATA_BUF, 8'h00, 8);
        chk(q, 8'hd4);
        wb(1'b1, `SBU_OFS_CTRL_ONE, 8'h01);
        xfer(1'b0, `SBU_OFS_DATA_BUF, 8'h00, 1);
        chk(q, 8'he5);
        st(8'ha1);
        wb(1'b1, `SBU_OFS_CTRL_TWO, 8'hd0);
        wait_free();
        $display("test master read done");
        wb(1'b1, `SBU_OFS_OWN_ADDR, 8'h33);
        for (int i = 0; i < 2; i++) begin
            slave_case(i ? 8'h00 : 8'h66, i ? 8'h26 : 8'h24);
        end
        $display("test slave address done");
        close_out();
    end
endmodule
